/* File: rtl/twowire_pkg.sv */
// Shared constants, register map and state encoding for the two-wire controller
package twowire_pkg;
  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CFG = 8'h09;
  localparam logic [7:0] IDX_STAT = 8'h28;
  localparam logic [7:0] IDX_DATA = 8'h29;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int ADDR_MSB = 31;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int TRANS_ACTIVE = 1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Pin routing configuration fields
  // ----------------------------------------------------------------
  localparam int B_POS = 7;
  localparam int B_VAC_POL = 5;
  localparam int B_VAL_POL = 4;
  localparam int B_WHI = 1;
  localparam int B_WLO = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WR_MASK = 8'hb3;
  localparam logic [1:0] PW_NONE = 2'h0;
  localparam logic [1:0] PW_8 = 2'h1;
  localparam logic [1:0] PW_16 = 2'h2;
  localparam logic [1:0] PW_24 = 2'h3;
  // Port usage mask: bit0 port 0, bit1 port 1, bit2 port 3
  localparam logic [2:0] PORTS_NONE = 3'h0;
  localparam logic [2:0] PORTS_8 = 3'h1;
  localparam logic [2:0] PORTS_16 = 3'h3;
  localparam logic [2:0] PORTS_24 = 3'h7;
  localparam logic [1:0] OD_NONE = 2'h0;
  localparam logic [1:0] OD_P1 = 2'h1;
  localparam logic [1:0] OD_P2 = 2'h2;
  localparam logic [1:0] PIN_LOW = 2'h0;

  // ----------------------------------------------------------------
  // Status and control fields
  // ----------------------------------------------------------------
  localparam int S_MSEL = 7;
  localparam int S_CONT = 6;
  localparam int S_XMIT = 5;
  localparam int S_ACK = 4;
  localparam int S_ADDR = 3;
  localparam int S_ARB = 2;
  localparam int S_RSTOP = 1;
  localparam int S_EN = 0;

  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int HALF_NS = 5000;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'((HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] FULL_CYC = CNT_W'(2 * ((HALF_NS + CLK_NS - 1) / CLK_NS));
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_BIT_LO = 4'h3,
    ST_BIT_HI = 4'h2,
    ST_ACK_LO = 4'h6,
    ST_ACK_HI = 4'h7,
    ST_WAIT = 4'h5,
    ST_STOP = 4'h4,
    ST_RSTART = 4'hc
  } tw_state_e;

  // Parallel width code to port usage mask
  function automatic logic [2:0] width_ports(input logic [1:0] w);
    case (w)
      PW_24: width_ports = PORTS_24;
      PW_16: width_ports = PORTS_16;
      PW_8: width_ports = PORTS_8;
      default: width_ports = PORTS_NONE;
    endcase
  endfunction : width_ports
endpackage : twowire_pkg

/* File: rtl/twowire_sync.sv */
// Two-flop synchroniser for the four port pins that may carry the bus
`timescale 1ns/10ps
module twowire_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] d,
  output logic [3:0] q
);
  logic [3:0] meta;
  logic [3:0] next_meta;
  logic [3:0] next_q;

  // Idle bus lines float high, so both stages reset high
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 4'hf;
      q <= 4'hf;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : twowire_sync

/* File: rtl/twowire_ctrl.sv */
// Two-wire bus controller with shared pin routing configuration
// Notes on behaviour
// - Reset clears the whole pin routing configuration register.
// - Parallel port is active whenever its width field is nonzero.
// - Width 11 uses ports 3,1,0; 10 ports 1,0; 01 port 0.
// - Upper width bit forces bus to port 2; else position bit picks port.
// - Configuration bits 7, 1 and 0 decide the pin-out.
// - Bits 5..2 serve the parallel port only; two are writable, two read-only.
// - Routing alone does not run the bus; the enable bit must be set.
// - Serial clock sits on bit 0, serial data on bit 1.
// - Enabled, the two low bits of the chosen port are open drain.
// - Hardware alone drives and samples both bus lines.
// - Works as master, addressed slave and among contending masters.
// - Interrupt on byte end, slave receive stop, and lost arbitration.
// - Bus is held, clock stretched low, until firmware answers.
// - Data register is separate transmit and receive bytes at one address.
// - Setting master select sends start then the first data byte.
// - Clearing master select from one to zero sends a stop.
// - After an interrupt stay idle until proceed is written or master select is cleared.
// - Lost arbitration clears master select, flags it, interrupts.
`timescale 1ns/10ps
module twowire_ctrl
  import twowire_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic inlatch_vacant,
  input wire logic outdata_valid,
  input wire logic [1:0] p1_in,
  input wire logic [1:0] p2_in,
  output logic [1:0] p1_out,
  output logic [1:0] p1_oe,
  output logic [1:0] p2_out,
  output logic [1:0] p2_oe,
  output logic [1:0] od_force,
  output logic par_active,
  output logic [2:0] par_ports,
  output logic twowire_irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic dp_valid, dp_write, dp_ok, rd_done;
  logic next_dp_valid, next_dp_write, next_dp_ok, next_rd_done;
  logic [7:0] dp_idx, next_dp_idx;
  logic [31:0] next_hrdata;
  logic [7:0] rd_val, cfg, next_cfg;
  logic wr_go, wr_cfg, wr_data, stat_wr, cont_req, msel_drop, busy;
  logic [3:0] pins_s;
  logic sel_p2, scl_s, sda_s, scl_r, sda_r, next_scl_r, next_sda_r;
  logic scl_rise, scl_fall, start_det, stop_det, half;
  tw_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [2:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, tx_byte, next_tx, rx_byte, next_rx;
  logic scl_low, sda_low, mst, tx_now, samp, next_scl_low, next_sda_low;
  logic next_mst, next_tx_now, next_samp;
  logic en, msel, xmit, ack_ctl, ack_rx, addr_f, arb_lost, rstop, restart;
  logic next_en, next_msel, next_xmit, next_ack_ctl, next_ack_rx, next_addr_f;
  logic next_arb_lost, next_rstop, next_restart, next_irq;
  logic [1:0] next_p1_oe, next_p2_oe, next_od_force;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Reads take one wait state so read data comes from a flip-flop
  assign hreadyout = !(dp_valid && !dp_write && !rd_done);
  assign hresp = 1'b0;
  assign wr_go = dp_valid && dp_write && dp_ok;
  assign wr_cfg = wr_go && (dp_idx == IDX_CFG);
  assign wr_data = wr_go && (dp_idx == IDX_DATA);
  // Status writes are locked out while a transfer is running
  assign stat_wr = wr_go && (dp_idx == IDX_STAT) && !busy;
  assign cont_req = stat_wr && hwdata[S_CONT];
  assign msel_drop = stat_wr && msel && !hwdata[S_MSEL];
  assign busy = (state != ST_IDLE) && (state != ST_WAIT);

  // Read value by index; unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (dp_ok) begin
      case (dp_idx)
        IDX_CFG: rd_val = {cfg[B_POS], 1'b0, cfg[B_VAC_POL], cfg[B_VAL_POL],
                           inlatch_vacant, outdata_valid, cfg[B_WHI:B_WLO]};
        IDX_STAT: rd_val = {msel, busy, xmit, xmit ? ack_rx : ack_ctl, addr_f, arb_lost, rstop, en};
        IDX_DATA: rd_val = rx_byte;
        default: rd_val = 8'h00;
      endcase
    end
  end

  // Address phase capture and read data register
  always_comb begin
    next_dp_valid = dp_valid;
    next_dp_write = dp_write;
    next_dp_ok = dp_ok;
    next_dp_idx = dp_idx;
    next_rd_done = rd_done;
    next_hrdata = hrdata;
    if (hreadyout) begin
      next_dp_valid = hsel && htrans[TRANS_ACTIVE] && hready;
      next_dp_write = hwrite;
      next_dp_idx = haddr[IDX_MSB:IDX_LSB];
      next_dp_ok = (haddr[ADDR_MSB:IDX_MSB+1] == '0) && (haddr[IDX_LSB-1:0] == '0) && (hsize == HSIZE_WORD);
      next_rd_done = 1'b0;
    end else begin
      next_rd_done = 1'b1;
      next_hrdata = {24'h00_0000, rd_val};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_ok <= 1'b0;
      dp_idx <= 8'h00;
      rd_done <= 1'b0;
      hrdata <= RD_ZERO;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_ok <= next_dp_ok;
      dp_idx <= next_dp_idx;
      rd_done <= next_rd_done;
      hrdata <= next_hrdata;
    end
  end

  a_read_wait: assert property (dp_valid && !dp_write && !rd_done |-> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");

  // ----------------------------------------------------------------
  // Configuration and pin routing
  // ----------------------------------------------------------------
  // Only routing, width and polarity bits are stored; flags read live
  assign next_cfg = wr_cfg ? (hwdata[7:0] & CFG_WR_MASK) : cfg;
  assign sel_p2 = cfg[B_WHI] || cfg[B_POS];
  assign par_active = cfg[B_WHI:B_WLO] != PW_NONE;
  assign par_ports = width_ports(cfg[B_WHI:B_WLO]);
  assign scl_s = sel_p2 ? pins_s[2] : pins_s[0];
  assign sda_s = sel_p2 ? pins_s[3] : pins_s[1];
  assign p1_out = PIN_LOW;
  assign p2_out = PIN_LOW;

  // Pins only pull low, never drive high: open drain while enabled
  always_comb begin
    next_p1_oe = (en && !sel_p2) ? {sda_low, scl_low} : PIN_LOW;
    next_p2_oe = (en && sel_p2) ? {sda_low, scl_low} : PIN_LOW;
    next_od_force = !en ? OD_NONE : (sel_p2 ? OD_P2 : OD_P1);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= CFG_RESET;
      p1_oe <= PIN_LOW;
      p2_oe <= PIN_LOW;
      od_force <= OD_NONE;
    end else begin
      cfg <= next_cfg;
      p1_oe <= next_p1_oe;
      p2_oe <= next_p2_oe;
      od_force <= next_od_force;
    end
  end

  twowire_sync u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({p2_in, p1_in}),
    .q(pins_s)
  );

  a_cfg_clear: assert property ($rose(rst_b) |-> cfg == CFG_RESET)
    else $error("configuration not cleared by reset");
  a_par_enable: assert property (wr_cfg && hwdata[B_WHI:B_WLO] != PW_NONE |=> par_active)
    else $error("parallel port not active for nonzero width");
  a_par_decode: assert property (cfg[B_WHI:B_WLO] == PW_16 |-> par_ports == PORTS_16 && par_active)
    else $error("parallel width decoded wrongly");
  a_route_p2: assert property (en && (cfg[B_POS] || cfg[B_WHI]) |=> od_force == OD_P2)
    else $error("bus not routed to port 2");
  a_od_idle: assert property (!en |=> p1_oe == PIN_LOW && p2_oe == PIN_LOW && od_force == OD_NONE)
    else $error("pins driven while function disabled");
  a_scl_bit0: assert property (en && !sel_p2 && scl_low |=> p1_oe[0] && p2_oe == PIN_LOW)
    else $error("clock not on port 1 bit 0");

  // ----------------------------------------------------------------
  // Bus engine and status register
  // ----------------------------------------------------------------
  assign scl_rise = scl_s && !scl_r;
  assign scl_fall = !scl_s && scl_r;
  assign start_det = scl_s && scl_r && sda_r && !sda_s;
  assign stop_det = scl_s && scl_r && !sda_r && sda_s;
  assign half = cnt == HALF_CYC;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_shreg = shreg;
    next_tx = wr_data ? hwdata[7:0] : tx_byte;
    next_rx = rx_byte;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_mst = mst;
    next_tx_now = tx_now;
    next_samp = samp;
    next_scl_r = scl_s;
    next_sda_r = sda_s;
    next_en = en;
    next_msel = msel;
    next_xmit = xmit;
    next_ack_ctl = ack_ctl;
    next_ack_rx = ack_rx;
    next_addr_f = addr_f;
    next_arb_lost = arb_lost;
    next_rstop = rstop;
    next_restart = restart;
    next_irq = twowire_irq;
    // Firmware write first, so engine events below win over clears
    if (stat_wr) begin
      next_en = hwdata[S_EN];
      next_msel = hwdata[S_MSEL];
      next_xmit = hwdata[S_XMIT];
      next_ack_ctl = hwdata[S_ACK];
      next_restart = hwdata[S_ARB] && hwdata[S_MSEL];
      next_arb_lost = 1'b0;
      if (hwdata[S_CONT]) begin
        next_irq = 1'b0;
        next_addr_f = 1'b0;
        next_rstop = 1'b0;
      end
    end
    case (state)
      ST_IDLE: begin
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        if (stat_wr && hwdata[S_MSEL] && !msel && hwdata[S_EN] && scl_s && sda_s) begin
          next_state = ST_START;
          next_mst = 1'b1;
          next_cnt = '0;
        end else if (en && start_det) begin
          next_state = ST_BIT_LO;
          next_mst = 1'b0;
          next_bitn = '0;
          next_tx_now = 1'b0;
          next_addr_f = 1'b1;
        end
      end
      ST_START, ST_RSTART: begin
        next_cnt = cnt + 1'b1;
        next_sda_low = (state == ST_START) || (cnt >= FULL_CYC);
        next_scl_low = (state == ST_RSTART) && (cnt < HALF_CYC);
        if (state == ST_RSTART && cnt == FULL_CYC) begin
          next_state = ST_START;
          next_cnt = '0;
        end else if (state == ST_START && half) begin
          next_state = ST_BIT_LO;
          next_cnt = '0;
          next_bitn = '0;
          next_shreg = tx_byte;
          next_tx_now = 1'b1;
          next_scl_low = 1'b1;
        end
      end
      ST_BIT_LO: begin
        // Master data moves two cycles after its clock falls, never while it is high
        if (!mst || cnt != '0) next_sda_low = tx_now && !shreg[7];
        if (mst) begin
          next_scl_low = 1'b1;
          next_cnt = cnt + 1'b1;
          if (half) begin
            next_state = ST_BIT_HI;
            next_cnt = '0;
            next_scl_low = 1'b0;
          end
        end else if (scl_rise) begin
          next_state = ST_BIT_HI;
          next_samp = sda_s;
        end
      end
      ST_BIT_HI: begin
        // A slow or stretching device holds the clock low; count waits
        if (mst && scl_s) next_cnt = cnt + 1'b1;
        if (mst && scl_s && tx_now && !sda_low && !sda_s) begin
          next_msel = 1'b0;
          next_arb_lost = 1'b1;
          next_addr_f = 1'b1;
          next_irq = 1'b1;
          next_mst = 1'b0;
          next_state = ST_IDLE;
          next_scl_low = 1'b0;
          next_sda_low = 1'b0;
        end else if ((mst && half) || (!mst && scl_fall)) begin
          next_shreg = {shreg[6:0], mst ? sda_s : samp};
          next_cnt = '0;
          next_scl_low = mst;
          if (bitn == LAST_BIT) begin
            if (!tx_now) next_rx = {shreg[6:0], mst ? sda_s : samp};
            next_state = mst ? ST_ACK_LO : ST_WAIT;
            if (!mst) begin
              next_irq = 1'b1;
              next_scl_low = 1'b1;
              next_sda_low = 1'b0;
            end
          end else begin
            next_bitn = bitn + 1'b1;
            next_state = ST_BIT_LO;
          end
        end
      end
      ST_ACK_LO: begin
        if (!mst || cnt != '0) next_sda_low = !tx_now && ack_ctl;
        if (mst) begin
          next_scl_low = 1'b1;
          next_cnt = cnt + 1'b1;
          if (half) begin
            next_state = ST_ACK_HI;
            next_cnt = '0;
            next_scl_low = 1'b0;
          end
        end else begin
          next_scl_low = 1'b0;
          if (scl_rise) begin
            next_state = ST_ACK_HI;
            next_samp = sda_s;
          end
        end
      end
      ST_ACK_HI: begin
        if (mst) begin
          if (scl_s) next_cnt = cnt + 1'b1;
          if (half) begin
            if (tx_now) next_ack_rx = !sda_s;
            next_cnt = '0;
            next_scl_low = 1'b1;
            next_state = ST_WAIT;
            next_irq = 1'b1;
          end
        end else if (scl_fall) begin
          if (tx_now) next_ack_rx = !samp;
          next_state = ST_BIT_LO;
          next_bitn = '0;
          next_shreg = tx_byte;
          next_tx_now = xmit;
          next_sda_low = 1'b0;
        end
      end
      ST_WAIT: begin
        // Clock stays low until firmware answers the interrupt
        next_scl_low = 1'b1;
        next_sda_low = 1'b0;
        if (mst && msel_drop) begin
          next_state = ST_STOP;
          next_cnt = '0;
        end else if (cont_req) begin
          next_cnt = '0;
          if (!mst) begin
            next_state = ST_ACK_LO;
          end else if (hwdata[S_ARB] && hwdata[S_MSEL]) begin
            next_state = ST_RSTART;
            next_restart = 1'b0;
          end else begin
            next_state = ST_BIT_LO;
            next_bitn = '0;
            next_shreg = tx_byte;
            next_tx_now = hwdata[S_XMIT];
          end
        end
      end
      ST_STOP: begin
        next_cnt = cnt + 1'b1;
        next_sda_low = 1'b1;
        next_scl_low = cnt < HALF_CYC;
        if (cnt == FULL_CYC) begin
          next_state = ST_IDLE;
          next_sda_low = 1'b0;
          next_mst = 1'b0;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Slave watches for stop and repeated start at any point of a frame
    if (!mst && state != ST_IDLE) begin
      if (stop_det) begin
        next_state = ST_IDLE;
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        if (!tx_now && ack_ctl) begin
          next_rstop = 1'b1;
          next_irq = 1'b1;
        end
      end else if (start_det) begin
        next_state = ST_BIT_LO;
        next_bitn = '0;
        next_tx_now = 1'b0;
        next_addr_f = 1'b1;
      end
    end
    // Disabling releases the pins and drops any pending request
    if (!next_en) begin
      next_state = ST_IDLE;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      next_mst = 1'b0;
      next_msel = 1'b0;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= '0;
      bitn <= '0;
      shreg <= 8'h00;
      tx_byte <= 8'h00;
      rx_byte <= 8'h00;
      {scl_low, sda_low, mst, tx_now, samp} <= 5'h00;
      {scl_r, sda_r} <= 2'h3;
      {en, msel, xmit, ack_ctl, ack_rx} <= 5'h00;
      {addr_f, arb_lost, rstop, restart, twowire_irq} <= 5'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      shreg <= next_shreg;
      tx_byte <= next_tx;
      rx_byte <= next_rx;
      {scl_low, sda_low, mst, tx_now, samp} <= {next_scl_low, next_sda_low, next_mst, next_tx_now, next_samp};
      {scl_r, sda_r} <= {next_scl_r, next_sda_r};
      {en, msel, xmit, ack_ctl, ack_rx} <= {next_en, next_msel, next_xmit, next_ack_ctl, next_ack_rx};
      {addr_f, arb_lost, rstop, restart, twowire_irq} <= {next_addr_f, next_arb_lost, next_rstop, next_restart, next_irq};
    end
  end

  a_master_start: assert property (state == ST_IDLE && stat_wr && hwdata[S_MSEL] && !msel && hwdata[S_EN]
      && scl_s && sda_s |=> state == ST_START ##1 sda_low && !scl_low)
    else $error("master select did not begin a start");
  a_stop_gen: assert property (state == ST_WAIT && mst && msel_drop |=> state == ST_STOP ##1 sda_low && scl_low)
    else $error("clearing master select gave no stop");
  a_wait_hold: assert property (state == ST_WAIT |-> scl_low && !busy)
    else $error("clock not held during wait");
  a_wait_idle: assert property (state == ST_WAIT && !stat_wr |=> state == ST_WAIT)
    else $error("left wait without proceed");
  a_byte_irq: assert property ($rose(state == ST_WAIT) |-> twowire_irq)
    else $error("byte end raised no interrupt");
  a_irq_level: assert property (twowire_irq && !stat_wr |=> twowire_irq)
    else $error("interrupt dropped without firmware");
  a_arb_lost: assert property (state == ST_BIT_HI && mst && scl_s && tx_now && !sda_low && !sda_s
      |=> !msel && arb_lost && twowire_irq && state == ST_IDLE)
    else $error("lost arbitration not handled");
  a_data_split: assert property (wr_data |=> tx_byte == $past(hwdata[7:0]) && $stable(rx_byte))
    else $error("data write disturbed receive byte");
endmodule : twowire_ctrl

/* File: sim/i2c_far_end.sv */
// Far-side bus target model that acknowledges only the first byte it receives after each start
`timescale 1ns/10ps
module i2c_far_end (
  input wire logic scl,
  input wire logic sda,
  output logic ack_low,
  output logic [7:0] rx_byte
);
  int n = 0;
  initial ack_low = 1'b0;
  initial rx_byte = 8'h00;
  // A start (data falls while clock high) restarts the count
  always @(negedge sda) if (scl) n = 0;
  // Bits shift in MSB first on the rising clock
  always @(posedge scl) begin
    if (n < 8) rx_byte = {rx_byte[6:0], sda};
    n = n + 1;
  end
  // Pull data low for the ack slot only, then release to the pull-up
  always @(negedge scl) ack_low = (n == 8);
endmodule : i2c_far_end

/* File: sim/test_twowire_ctrl.sv */
// Self-checking bench for the two-wire controller and its pin routing
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module test_twowire_ctrl
  import twowire_pkg::*;
;
  logic mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, iv = 0, ov = 0, hready, hreadyout, hresp, irq, ack_low;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, p1_out, p1_oe, p2_out, p2_oe, od_force;
  logic [2:0] hsize = HSIZE_WORD, par_ports;
  logic [7:0] w, rx_byte;
  logic [15:0] seed = 16'h0063;
  logic par_active, scl1, sda1, m_scl = 0, m_sda = 0;
  int n_fail = 0, compares = 0, cyc = 0, n;
  // ----------------------------------------
  // Clock, wires and instances
  // ----------------------------------------
  always #10 mclk = ~mclk;
  assign hready = hreadyout;
  // Open drain: a line is low if anyone pulls it, else the pull-up wins
  assign scl1 = ~p1_oe[0];
  assign sda1 = ~(p1_oe[1] | ack_low);
  twowire_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .inlatch_vacant(iv), .outdata_valid(ov), .p1_in({sda1, scl1}), .p2_in(~(p2_oe | {m_sda, m_scl})), .p1_out(p1_out),
    .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .od_force(od_force), .par_active(par_active),
    .par_ports(par_ports), .twowire_irq(irq));
  i2c_far_end u_far (.scl(scl1), .sda(sda1), .ack_low(ack_low), .rx_byte(rx_byte));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [2:0] exp_ports(input logic [1:0] c);
    exp_ports = (c == 2'h3) ? 3'h7 : (c == 2'h2) ? 3'h3 : {2'h0, c[0]};
  endfunction : exp_ports
  // Single word transfer; waits on the slave however long it takes
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : ahb
  // Far master on port 2: a high argument pulls that line low for a half period of the 160 ns link clock
  task automatic pins(input logic c, input logic d);
    m_scl <= c;
    m_sda <= d;
    repeat (4) @(posedge mclk);
  endtask : pins
  task automatic give_verdict;
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Hang guard, well above the single byte and stop that take longest
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin n_fail++; give_verdict(); end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    ahb(1'b0, 32'h24, 8'h00, r); `CHK(r, 32'h0)
    `CHK(par_active, 1'b0)
    // First four passes force every width code, the rest are random
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      w = (i < 4) ? {seed[7:2], 2'(i)} : seed[7:0];
      iv <= seed[8]; ov <= seed[9];
      ahb(1'b1, 32'h24, w, r);
      ahb(1'b1, 32'ha0, 8'h01, r);
      repeat (3) @(posedge mclk);
      `CHK(od_force, (w[7] | w[1]) ? 2'h2 : 2'h1)
      ahb(1'b0, 32'h24, 8'h00, r); `CHK(r, {24'h0, w & 8'hb3 | {4'h0, iv, ov, 2'h0}})
      `CHK(par_active, w[1:0] != 2'h0)
      `CHK(par_ports, exp_ports(w[1:0]))
      ahb(1'b1, 32'ha0, 8'h00, r);
      repeat (3) @(posedge mclk);
      `CHK(od_force, 2'h0)
    end
    ahb(1'b0, 32'h30, 8'h00, r); `CHK(r, 32'h0)
    // Master sends one address byte to the far side, then stops
    ahb(1'b1, 32'h24, 8'h00, r);
    ahb(1'b1, 32'ha0, 8'h01, r);
    ahb(1'b1, 32'ha4, 8'ha5, r);
    ahb(1'b1, 32'ha0, 8'h81, r);
    n = 0;
    while (irq !== 1'b1 && n < 9000) begin @(posedge mclk); n++; end
    `CHK(irq, 1'b1)
    `CHK(rx_byte, 8'ha5)
    // Status is only looked at once the interrupt is up
    ahb(1'b0, 32'ha0, 8'h00, r); `CHK(r[7:6], 2'h2)
    repeat (300) @(posedge mclk);
    `CHK(scl1, 1'b0)
    `CHK(irq, 1'b1)
    `CHK({hresp, p2_out, p1_out}, 5'h00)
    ahb(1'b1, 32'ha0, 8'h01, r);
    n = 0;
    while ((scl1 & sda1) !== 1'b1 && n < 2000) begin @(posedge mclk); n++; end
    repeat (2) @(posedge mclk);
    `CHK({scl1, sda1}, 2'h3)
    // A stop without proceed leaves the interrupt up; proceed clears it
    `CHK(irq, 1'b1)
    ahb(1'b1, 32'ha0, 8'h41, r);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    // Far master on port 2 sends a random byte; the device holds the clock, acks, then sees the stop
    ahb(1'b1, 32'h24, 8'h80, r);
    seed = lfsr(seed);
    pins(1'b0, 1'b1);
    for (int k = 7; k >= 0; k--) begin
      pins(1'b1, !seed[k]);
      pins(1'b0, !seed[k]);
    end
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b0);
    `CHK({irq, p2_oe[0]}, 2'h3)
    ahb(1'b0, 32'ha4, 8'h00, r); `CHK(r, {24'h0, seed[7:0]})
    ahb(1'b1, 32'ha0, 8'h51, r);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    `CHK({irq, p2_oe[1]}, 2'h1)
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    ahb(1'b0, 32'ha0, 8'h00, r); `CHK({irq, r[6], r[1]}, 3'h5)
    give_verdict();
  end
endmodule : test_twowire_ctrl
